// ===== swps_sequencer.sv
// standby wake sequencer: reset release, aux power assert, button fail-safe
`timescale 1ns/100ps
// How it works
// - hold system reset for programmed edges
// - release count resets to 100h
// - countdown waits for work reset, core ok
// - release count used only when enabled
// - release needs count elapsed and core ok
// - lock bit freezes aux and button registers
// - reserved bits read zero, writes accepted
// - aux asserts at wake when delay off
// - aux kept on ignores its enable
// - aux asserts after programmed wake delay
// - aux and reset countdowns run independently
// - wake ignored while work delays pending
// - fail-safe works only when enabled
// - held button drops main and aux power
// - button still held keeps device standing by
// - button re-press restarts fail-safe count
// - delay write while pressed restarts count
// - release enable resets to one
// - release lock freezes release register
module swps_sequencer (
	input wire logic clk,
	input wire logic srst,
	input wire logic standby_reset_in_n, // standby well reset, clears locks
	input wire swps_pkg::swps_io_req_s io_req, // register write port
	input wire logic io_rd, // read strobe
	output logic [31:0] io_rdata, // read data, registered
	input wire logic power_button_n, // power button, active low
	input wire logic working_reset_n, // working reset input, active low
	input wire logic core_volt_ok, // low-voltage detector reports normal
	input wire logic standby_enter, // pulse: standby entry
	input wire logic aux_off_at_entry, // level: aux drops on this entry from run
	input wire logic standby_wakeup, // pulse: wakeup event
	input wire logic work_delay_pending, // normal/abnormal to work delay running
	output logic system_reset_n, // reset to non-standby circuits
	output logic work_aux, // auxiliary working power
	output logic working_off, // fail-safe forces main power off
	output logic in_standby // sequencer is standing by
);
	logic [31:0] rr_q; // reset release register
	logic [31:0] aux_q; // aux wake delay register
	logic [31:0] btn_q; // button fail-safe register
	logic [31:0] thr_q; // thermal register, storage only
	logic [11:0] div_q; // standby tick divider
	logic tick; // one standby clock edge
	logic [2:0] sync_out; // synchronised inputs
	logic btn_on; // button pressed after sync
	logic wrst_off; // working reset released after sync
	logic sby_rst; // standby reset after sync
	logic btn_prev_q; // button level at previous cycle
	swps_pkg::swps_state_e state_q;
	logic wake_ok; // wakeup accepted this cycle
	logic rr_done, aux_done, btn_done;
	logic aux_load, btn_load;
	logic tripped_q; // last power removal was the fail-safe
	logic aux_wait_q; // aux waits for its countdown
	logic rr_run;
	logic rr_done_eff; // release count finished, or the count is not in use
	logic wr_rr, wr_aux, wr_btn, wr_thr;
	logic regs_rst;

	// masked write value, shared by all registers
	function automatic logic [31:0] wmask(input logic [31:0] d);
		return d & swps_pkg::RD_MASK;
	endfunction

	// address match for a write strobe
	function automatic logic hit(input swps_pkg::swps_io_req_s r, input logic [7:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction

	// inputs cross in together; idle levels avoid a false press at reset
	swps_sync #(.W(3), .INIT(3'b111)) u_sync (
		.clk(clk),
		.srst(srst),
		.din({power_button_n, working_reset_n, standby_reset_in_n}),
		.dout(sync_out)
	);
	assign btn_on = ~sync_out[2];
	assign wrst_off = sync_out[1];
	assign sby_rst = ~sync_out[0];
	assign regs_rst = srst | sby_rst;

	// standby clock edge from the system clock
	always_ff @(posedge clk) begin
		if (srst || div_q == swps_pkg::TICK_LAST) begin
			div_q <= 12'h000;
		end else begin
			div_q <= div_q + 12'h001;
		end
	end
	assign tick = (div_q == swps_pkg::TICK_LAST);

	assign wr_rr = hit(io_req, swps_pkg::OFS_RESET_RELEASE);
	assign wr_aux = hit(io_req, swps_pkg::OFS_AUX_WAKE);
	assign wr_btn = hit(io_req, swps_pkg::OFS_BUTTON_FS);
	assign wr_thr = hit(io_req, swps_pkg::OFS_THERMAL_FS);

	// reset release register; standby reset restores the default and unlocks
	always_ff @(posedge clk) begin
		if (regs_rst) begin
			rr_q <= swps_pkg::RST_RESET_RELEASE;
		end else if (wr_rr && !rr_q[swps_pkg::LOCK_BIT]) begin
			rr_q <= wmask(io_req.wdata);
		end
	end

	// aux wake delay register
	always_ff @(posedge clk) begin
		if (regs_rst) begin
			aux_q <= swps_pkg::RST_AUX_WAKE;
		end else if (wr_aux && !aux_q[swps_pkg::LOCK_BIT]) begin
			aux_q <= wmask(io_req.wdata);
		end
	end

	// button fail-safe register
	always_ff @(posedge clk) begin
		if (regs_rst) begin
			btn_q <= swps_pkg::RST_BUTTON_FS;
		end else if (wr_btn && !btn_q[swps_pkg::LOCK_BIT]) begin
			btn_q <= wmask(io_req.wdata);
		end
	end

	// thermal register holds its value only; its function lives elsewhere
	always_ff @(posedge clk) begin
		if (regs_rst) begin
			thr_q <= swps_pkg::RST_THERMAL_FS;
		end else if (wr_thr && !thr_q[swps_pkg::LOCK_BIT]) begin
			thr_q <= wmask(io_req.wdata);
		end
	end

	// read data; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (srst) begin
			io_rdata <= 32'h00000000;
		end else if (io_rd) begin
			case (io_req.addr)
				swps_pkg::OFS_RESET_RELEASE: io_rdata <= rr_q;
				swps_pkg::OFS_AUX_WAKE: io_rdata <= aux_q;
				swps_pkg::OFS_BUTTON_FS: io_rdata <= btn_q;
				swps_pkg::OFS_THERMAL_FS: io_rdata <= thr_q;
				default: io_rdata <= 32'h00000000;
			endcase
		end
	end

	// a wake after a fail-safe trip waits for the button to be let go
	assign wake_ok = (state_q == swps_pkg::ST_STANDBY) && standby_wakeup
		&& !work_delay_pending
		&& !(tripped_q && btn_on);

	// reset countdown only runs once work reset is gone and core is good
	assign rr_run = wrst_off && core_volt_ok;

	swps_count u_rr_cnt (
		.clk(clk),
		.srst(srst),
		.load(wake_ok),
		.value(rr_q[swps_pkg::DLY_W-1:0]),
		.run(rr_run),
		.tick(tick),
		.done(rr_done)
	);

	// separate counter so aux timing never waits on reset timing
	assign aux_load = wake_ok;
	swps_count u_aux_cnt (
		.clk(clk),
		.srst(srst),
		.load(aux_load),
		.value(aux_q[swps_pkg::DLY_W-1:0]),
		.run(1'b1),
		.tick(tick),
		.done(aux_done)
	);

	// button count restarts on a fresh press or a delay write while pressed
	assign btn_load = (btn_on && !btn_prev_q)
		|| (btn_on && wr_btn && !btn_q[swps_pkg::LOCK_BIT]);
	swps_count u_btn_cnt (
		.clk(clk),
		.srst(srst),
		.load(btn_load),
		.value(btn_load && wr_btn ? io_req.wdata[swps_pkg::DLY_W-1:0]
			: btn_q[swps_pkg::DLY_W-1:0]),
		.run(btn_on && btn_q[swps_pkg::EN_BIT]),
		.tick(tick),
		.done(btn_done)
	);

	// previous button level for press detection
	always_ff @(posedge clk) begin
		if (srst) begin
			btn_prev_q <= 1'b0;
		end else begin
			btn_prev_q <= btn_on;
		end
	end

	// fail-safe fires once per press: the count ended and the press lasts
	logic fs_fire;
	assign fs_fire = btn_done && btn_on && btn_prev_q && btn_q[swps_pkg::EN_BIT]
		&& !tripped_q;

	// sequencer state
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= swps_pkg::ST_RUN;
		end else begin
			case (state_q)
				swps_pkg::ST_RUN: begin
					if (standby_enter || fs_fire) begin
						state_q <= swps_pkg::ST_STANDBY;
					end
				end
				swps_pkg::ST_STANDBY: begin
					if (wake_ok) begin
						state_q <= swps_pkg::ST_WAKE;
					end
				end
				swps_pkg::ST_WAKE: begin
					// release waits for the later of count and core supply
					if (fs_fire || standby_enter) begin
						state_q <= swps_pkg::ST_STANDBY;
					end else if (rr_done_eff && core_volt_ok) begin
						state_q <= swps_pkg::ST_RUN;
					end
				end
				default: state_q <= swps_pkg::ST_RUN;
			endcase
		end
	end

	// with the enable low the count is skipped; only core supply gates release
	assign rr_done_eff = rr_q[swps_pkg::EN_BIT] ? rr_done : 1'b1;

	// system reset follows the state; low in standby and during release wait
	always_ff @(posedge clk) begin
		if (srst) begin
			system_reset_n <= 1'b0;
		end else begin
			system_reset_n <= (state_q == swps_pkg::ST_RUN);
		end
	end

	// fail-safe trip memory, cleared by an accepted wake
	always_ff @(posedge clk) begin
		if (srst) begin
			tripped_q <= 1'b0;
		end else if (fs_fire) begin
			tripped_q <= 1'b1;
		end else if (wake_ok) begin
			tripped_q <= 1'b0;
		end
	end

	// main power removal follows the trip until the next wake
	always_ff @(posedge clk) begin
		if (srst) begin
			working_off <= 1'b0;
		end else if (fs_fire) begin
			working_off <= 1'b1;
		end else if (wake_ok) begin
			working_off <= 1'b0;
		end
	end

	// aux power: dropped by entry from run or by trip, restored at or after wake
	always_ff @(posedge clk) begin
		if (srst) begin
			work_aux <= 1'b1;
			aux_wait_q <= 1'b0;
		end else if (fs_fire) begin
			work_aux <= 1'b0;
			aux_wait_q <= 1'b0;
		end else if (state_q == swps_pkg::ST_RUN && standby_enter && aux_off_at_entry) begin
			work_aux <= 1'b0;
			aux_wait_q <= 1'b0;
		end else if (wake_ok) begin
			if (work_aux) begin
				aux_wait_q <= 1'b0;
			end else if (!aux_q[swps_pkg::EN_BIT]) begin
				work_aux <= 1'b1;
			end else begin
				aux_wait_q <= 1'b1;
			end
		end else if (aux_wait_q && aux_done) begin
			work_aux <= 1'b1;
			aux_wait_q <= 1'b0;
		end
	end

	assign in_standby = (state_q == swps_pkg::ST_STANDBY);

	// checks
	a_lock_holds_aux: assert property (@(posedge clk) disable iff (regs_rst)
		$past(aux_q[swps_pkg::LOCK_BIT]) && !$past(regs_rst) |-> $stable(aux_q))
		else $error("aux register changed while locked");
	a_lock_holds_btn: assert property (@(posedge clk) disable iff (regs_rst)
		$past(btn_q[swps_pkg::LOCK_BIT]) && !$past(regs_rst) |-> $stable(btn_q))
		else $error("button register changed while locked");
	a_rsvd_read_zero: assert property (@(posedge clk) disable iff (srst)
		io_rdata[29:20] == 10'h000)
		else $error("reserved bits read nonzero");
	a_wake_blocked: assert property (@(posedge clk) disable iff (srst)
		in_standby && work_delay_pending |=> in_standby)
		else $error("wake accepted while work delay pending");
	a_held_button_stay: assert property (@(posedge clk) disable iff (srst)
		in_standby && tripped_q && btn_on |=> in_standby)
		else $error("woke while button still held after trip");
	a_aux_immediate: assert property (@(posedge clk) disable iff (srst)
		wake_ok && !aux_q[swps_pkg::EN_BIT] |=> work_aux)
		else $error("aux not asserted at wake with delay off");
	a_release_needs_core: assert property (@(posedge clk) disable iff (srst)
		state_q == swps_pkg::ST_WAKE && !core_volt_ok |=> state_q != swps_pkg::ST_RUN)
		else $error("reset released with core supply low");
	a_trip_drops_power: assert property (@(posedge clk) disable iff (srst)
		fs_fire |=> !work_aux && working_off ##1 !system_reset_n)
		else $error("fail-safe did not remove power");
	a_no_trip_disabled: assert property (@(posedge clk) disable iff (srst)
		$rose(working_off) |-> $past(btn_q[swps_pkg::EN_BIT]))
		else $error("fail-safe fired while disabled");
	a_reset_in_wake: assert property (@(posedge clk) disable iff (srst)
		state_q == swps_pkg::ST_WAKE |=> !system_reset_n)
		else $error("system reset released during countdown");
	c_wake_release: cover property (@(posedge clk) disable iff (srst)
		state_q == swps_pkg::ST_WAKE ##1 state_q == swps_pkg::ST_RUN);
	c_fail_safe: cover property (@(posedge clk) disable iff (srst) fs_fire);
	c_aux_delayed: cover property (@(posedge clk) disable iff (srst)
		aux_wait_q && aux_done);
endmodule // swps_sequencer

// ===== swps_pkg.sv
// shared constants and carrier types for the standby wake power sequencer
package swps_pkg;
	// register offsets on the power-management i/o port
	localparam logic [7:0] OFS_RESET_RELEASE = 8'h38;
	localparam logic [7:0] OFS_AUX_WAKE = 8'h3C;
	localparam logic [7:0] OFS_BUTTON_FS = 8'h40;
	localparam logic [7:0] OFS_THERMAL_FS = 8'h44;
	// field positions shared by every delay register
	localparam int LOCK_BIT = 31;
	localparam int EN_BIT = 30;
	localparam int DLY_W = 20;
	// reserved bits 29:20 never store
	localparam logic [31:0] RD_MASK = 32'hC00FFFFF;
	// reset values
	localparam logic [31:0] RST_RESET_RELEASE = 32'h40000100;
	localparam logic [31:0] RST_AUX_WAKE = 32'h00000000;
	localparam logic [31:0] RST_BUTTON_FS = 32'h00000000;
	localparam logic [31:0] RST_THERMAL_FS = 32'h00000000;
	// standby clock derived from the 125 MHz system clock
	localparam int CLK_HZ = 125000000;
	localparam int SBY_HZ = 32768;
	localparam int TICK_DIV = CLK_HZ / SBY_HZ;
	localparam logic [11:0] TICK_LAST = 12'(TICK_DIV - 1);
	// default release time, 256 standby edges
	localparam int RESET_DEFAULT_MS = 8;
	// sequencer states
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_STANDBY = 2'b01,
		ST_WAKE = 2'b10
	} swps_state_e;
	// one access on the i/o port
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} swps_io_req_s;
endpackage

// ===== swps_sync.sv
// two flip-flop synchroniser for a small vector of levels
`timescale 1ns/100ps
module swps_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q; // first stage, read only by the second stage

	// two stages, both reset to the idle level
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= INIT;
			dout <= INIT;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule // swps_sync

// ===== swps_count.sv
// 20-bit countdown that advances on standby clock ticks
`timescale 1ns/100ps
module swps_count (
	input wire logic clk,
	input wire logic srst,
	input wire logic load,
	input wire logic [19:0] value,
	input wire logic run,
	input wire logic tick,
	output logic done
);
	logic [19:0] cnt_q; // edges still to wait
	logic busy_q; // countdown armed

	// a count of zero or one finishes on the first tick after run
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= 20'h00000;
			busy_q <= 1'b0;
			done <= 1'b0;
		end else if (load) begin
			cnt_q <= value;
			busy_q <= 1'b1;
			done <= 1'b0;
		end else if (busy_q && run && tick) begin
			if (cnt_q <= 20'h00001) begin
				busy_q <= 1'b0;
				done <= 1'b1;
			end else begin
				cnt_q <= cnt_q - 20'h00001;
			end
		end
	end
endmodule // swps_count

// ===== swps_partner.sv
// far side model: power button, reset network and core supply detector
`timescale 1ns/100ps
module swps_partner (
	input wire logic clk,
	input wire logic press, // bench asks for a button press
	input wire logic core_good, // bench sets the core supply state
	output logic power_button_n,
	output logic working_reset_n,
	output logic core_volt_ok
);
	// stretch counter; a press shorter than a standby edge could be missed
	int hold_q = 0;
	// keep the button down at least one full standby tick after the request
	always_ff @(posedge clk) begin
		if (press) begin
			hold_q <= swps_pkg::TICK_DIV + 1;
		end else if (hold_q != 0) begin
			hold_q <= hold_q - 1;
		end
	end
	assign power_button_n = !(press || hold_q != 0);
	// the reset network holds working reset while the core supply is bad
	assign core_volt_ok = core_good;
	assign working_reset_n = core_good;
endmodule // swps_partner

// ===== standby_wake_power_sequencer_test.sv
// self-checking bench for the standby wake power sequencer
`timescale 1ns/100ps
module standby_wake_power_sequencer_test;
	localparam int T = swps_pkg::TICK_DIV; // clk cycles per standby tick
	localparam int RS = 3, AX = 2, WO = 1, SB = 0; // indexes into ob
	logic clk = 1'b0, srst = 1'b1, sr_n = 1'b1, io_rd = 1'b0;
	logic press = 1'b0, core_good = 1'b1;
	logic standby_enter = 1'b0, aux_off = 1'b0, wake = 1'b0, pending = 1'b0;
	swps_pkg::swps_io_req_s io_req = '0;
	logic [31:0] io_rdata;
	logic pb_n, wr_n, cv_ok, system_reset_n, work_aux, working_off, in_standby;
	logic [3:0] ob; // watched outputs in one vector
	int err_count = 0, n_tests = 0;
	assign ob = {system_reset_n, work_aux, working_off, in_standby};
	always #4 clk = ~clk;
	swps_partner u_swps_partner (.clk(clk), .press(press), .core_good(core_good),
		.power_button_n(pb_n), .working_reset_n(wr_n), .core_volt_ok(cv_ok));
	swps_sequencer u_swps_sequencer (.clk(clk), .srst(srst), .standby_reset_in_n(sr_n),
		.io_req(io_req), .io_rd(io_rd), .io_rdata(io_rdata), .power_button_n(pb_n),
		.working_reset_n(wr_n), .core_volt_ok(cv_ok), .standby_enter(standby_enter),
		.aux_off_at_entry(aux_off), .standby_wakeup(wake),
		.work_delay_pending(pending), .system_reset_n(system_reset_n),
		.work_aux(work_aux), .working_off(working_off), .in_standby(in_standby));
	// verdict, reached from the main sequence or the watchdog
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk1(input string s, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %b got %b", s, e, g);
		end
	endtask
	task automatic chk32(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	// one write strobe on the register port
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk) io_req = '{wr: 1'b1, addr: a, wdata: d};
		@(negedge clk) io_req.wr = 1'b0;
	endtask
	// read strobe, data is held after the following edge
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk) begin
			io_rd = 1'b1;
			io_req.addr = a;
		end
		@(negedge clk) io_rd = 1'b0;
		@(negedge clk) chk32("io_rdata", e, io_rdata);
	endtask
	// wait a bounded number of cycles for one output, then judge it
	task automatic wt(input int i, input logic v, input int lim, output int n);
		n = 0;
		while (ob[i] !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk1("output wait", v, ob[i]);
	endtask
	task automatic pulse_enter(input logic off);
		@(negedge clk) begin
			standby_enter = 1'b1;
			aux_off = off;
		end
		@(negedge clk) standby_enter = 1'b0;
	endtask
	task automatic pulse_wake;
		@(negedge clk) wake = 1'b1;
		@(negedge clk) wake = 1'b0;
	endtask
	// reset values, reserved bits and an unmapped offset
	task automatic t_regs;
		rd(8'h38, 32'h40000100);
		rd(8'h3C, 32'h00000000);
		rd(8'h40, 32'h00000000);
		rd(8'h44, 32'h00000000);
		wr(8'h3C, 32'h7FF00002);
		rd(8'h3C, 32'h40000002);
		rd(8'h50, 32'h00000000);
	endtask
	// locks hold until the standby reset clears them
	task automatic t_lock;
		wr(8'h40, 32'h80000005);
		wr(8'h40, 32'h00000000);
		rd(8'h40, 32'h80000005);
		wr(8'h3C, 32'h80000007);
		wr(8'h3C, 32'h00000000);
		rd(8'h3C, 32'h80000007);
		wr(8'h38, 32'hC0000001);
		wr(8'h38, 32'h00000000);
		rd(8'h38, 32'hC0000001);
		@(negedge clk) sr_n = 1'b0;
		repeat (5) @(negedge clk);
		sr_n = 1'b1;
		repeat (4) @(negedge clk);
		rd(8'h40, 32'h00000000);
		rd(8'h3C, 32'h00000000);
		rd(8'h38, 32'h40000100);
	endtask
	// blocked wake, delayed aux, reset held by a bad core supply
	task automatic t_wake;
		int n;
		wr(8'h38, 32'h40000002);
		wr(8'h3C, 32'h40000002);
		pulse_enter(1'b1);
		wt(RS, 1'b0, 4, n);
		chk1("work_aux", 1'b0, work_aux);
		pending = 1'b1;
		pulse_wake();
		repeat (4) @(negedge clk);
		chk1("in_standby", 1'b1, in_standby);
		pending = 1'b0;
		core_good = 1'b0;
		pulse_wake();
		wt(AX, 1'b1, 3 * T, n);
		chk1("aux window", 1'b1, n > T && n <= 2 * T + 3);
		chk1("system_reset_n", 1'b0, system_reset_n);
		core_good = 1'b1;
		wt(RS, 1'b1, 2 * T + 8, n);
		// both edges are still owed; a count that ran while core was bad would release at once
		chk1("release window", 1'b1, n > T && n <= 2 * T + 6);
	endtask
	// aux at once with its delay off, zero release count, aux kept, release count off
	task automatic t_aux;
		int n;
		wr(8'h3C, 32'h00000000);
		wr(8'h38, 32'h40000000);
		pulse_enter(1'b1);
		wt(RS, 1'b0, 4, n);
		pulse_wake();
		@(negedge clk);
		chk1("work_aux", 1'b1, work_aux);
		wt(RS, 1'b1, T + 8, n);
		wr(8'h3C, 32'h40000003);
		wr(8'h38, 32'h00000005);
		pulse_enter(1'b0);
		repeat (3) @(negedge clk);
		chk1("work_aux", 1'b1, work_aux);
		pulse_wake();
		repeat (2) @(negedge clk);
		chk1("work_aux", 1'b1, work_aux);
		wt(RS, 1'b1, 8, n);
	endtask
	// fail-safe disabled, reloaded while held, tripped, held at wake, re-press restart
	task automatic t_btn;
		int n;
		wr(8'h40, 32'h00000001);
		press = 1'b1;
		repeat (2 * T) @(negedge clk);
		chk1("working_off", 1'b0, working_off);
		wr(8'h40, 32'h4000000F);
		repeat (T + 8) @(negedge clk);
		chk1("working_off", 1'b0, working_off);
		wr(8'h40, 32'h40000001);
		wt(WO, 1'b1, T + 8, n);
		chk1("work_aux", 1'b0, work_aux);
		chk1("in_standby", 1'b1, in_standby);
		pulse_wake();
		repeat (4) @(negedge clk);
		chk1("in_standby", 1'b1, in_standby);
		press = 1'b0;
		repeat (T + 8) @(negedge clk);
		pulse_wake();
		wt(RS, 1'b1, 8, n);
		chk1("working_off", 1'b0, working_off);
		chk1("in_standby", 1'b0, in_standby);
		// a short press leaves the long count part-way; the next press must start over
		wr(8'h40, 32'h4000000F);
		press = 1'b1;
		@(negedge clk) press = 1'b0;
		repeat (T + 8) @(negedge clk);
		wr(8'h40, 32'h40000001);
		press = 1'b1;
		wt(WO, 1'b1, T + 8, n);
		press = 1'b0;
	endtask
	// main sequence; reset is held for six cycles
	initial begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		t_regs();
		t_lock();
		t_wake();
		t_aux();
		t_btn();
		results();
	end
	// watchdog, well beyond the roughly twelve standby ticks the tests take
	initial begin
		#(8 * 22 * T);
		err_count++;
		$display("[ERR] watchdog exp done got timeout");
		results();
	end
endmodule // standby_wake_power_sequencer_test
